//--- src/ppfm_pkg.sv
// package: register map, field layout, reset values and pin select codes
package ppfm_pkg;
  // register offsets
  localparam logic [7:0] PORT_CONFIG_A_ADDR = 8'h10;
  localparam logic [7:0] PORT_CONFIG_B_ADDR = 8'h11;
  localparam logic [7:0] PORT_CONFIG_C_ADDR = 8'h12;
  localparam logic [7:0] TEST_REGISTER_ADDR = 8'h35;
  // reset values
  localparam logic [7:0] PORT_CONFIG_A_RST  = 8'h28;
  localparam logic [7:0] PORT_CONFIG_B_RST  = 8'h06;
  localparam logic [7:0] PORT_CONFIG_C_RST  = 8'h00;
  localparam logic [7:0] TEST_REGISTER_RST  = 8'h00;
  // field positions
  localparam int DATA_INV_BIT   = 0;
  localparam int DATA_SEL_LSB   = 1;
  localparam int IRQ_INV_BIT    = 3;
  localparam int IRQ_SEL_LSB    = 4;
  localparam int SO_INV_BIT     = 4;
  localparam int SO_SEL_LSB     = 5;
  localparam int SEP_SO_BIT     = 7;
  localparam int TEST_SEL_LSB   = 4;
  // data pin select codes
  localparam logic [1:0] DATA_HIZ  = 2'h0;
  localparam logic [1:0] DATA_LOW  = 2'h1;
  localparam logic [1:0] DATA_PSEUDO_RANDOM_GENERATOR = 2'h2;
  // irq pin select codes
  localparam logic [3:0] IRQ_HIZ    = 4'h0;
  localparam logic [3:0] IRQ_TEST_1 = 4'hE;
  localparam logic [3:0] IRQ_TEST_2 = 4'hF;
  // serial-output pin select codes
  localparam logic [2:0] SO_HIZ = 3'h0;
endpackage : ppfm_pkg

//--- src/ppfm_pin_if.sv
// interface: one pin's function source, polarity and enable
`timescale 1ns/100ps
interface ppfm_pin_if;
  logic src;   // selected function level
  logic inv;   // polarity inversion
  logic drive; // pin actively driven
  logic out;   // registered pin level
  logic oe;    // registered output enable
  modport ctl (output src, output inv, output drive, input out, input oe);
  modport drv (input src, input inv, input drive, output out, output oe);
endinterface : ppfm_pin_if

//--- src/ppfm_pin_drv.sv
// one port pin output stage: inversion and registered drive
`timescale 1ns/100ps
module ppfm_pin_drv
  import ppfm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // pin function
  ppfm_pin_if.drv  pin
);
  logic next_out;
  logic next_oe;

  // apply inversion only while driving
  always_comb begin
    next_oe  = pin.drive;
    next_out = pin.drive & (pin.src ^ pin.inv);
  end

  // register the pin so a source change never glitches it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin.out <= 1'b0;
      pin.oe  <= 1'b0;
    end else begin
      pin.out <= next_out;
      pin.oe  <= next_oe;
    end
  end
endmodule : ppfm_pin_drv

//--- src/ppfm_port_mux.sv
// port pin function multiplexer with its configuration registers
// Summary of operation
// - config registers choose port pin functions
// - data pin select: hiz, low, pseudo_random_generator
// - data invert bit zero, resets clear
// - irq select 2-7 picks listed sources; 0 hiz, 1 zero
// - irq codes 8,9 pa flags; 10-13 zero
// - irq codes 14,15 route test groups
// - group one: regulator, oscillator enables, kick
// - group two: limiter, calibration, timer, rssi, lock
// - irq invert bit resets to one
// - serial-out select bits 7:5, invert bit 4
// - serial-out select maps ready flags, modulation
// - separate serial output overrides serial-out select
`timescale 1ns/100ps
module ppfm_port_mux
  import ppfm_pkg::*;
(
  // clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RESET_N,
  // register port
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  // internal sources
  input  wire logic       PSEUDO_RANDOM_GENERATOR_OUT,
  input  wire logic       IRQ_REQ,
  input  wire logic       CLKGEN_OUT,
  input  wire logic       IQ_CAL_RUNNING,
  input  wire logic       LOCAL_OSC_READY,
  input  wire logic       RX_READY,
  input  wire logic       TX_READY,
  input  wire logic       POWER_AMP_ON,
  input  wire logic       POWER_AMP_ON_REQ,
  input  wire logic       TX_MOD,
  input  wire logic       REFERENCE_CLOCK_READY,
  input  wire logic       SPI_SDO,
  input  wire logic       SPI_SDO_EN,
  input  wire logic [7:0] TEST_GROUP_1,
  input  wire logic [7:0] TEST_GROUP_2,
  // pins
  output logic            DATA_PORT_PIN_O,
  output logic            DATA_PORT_PIN_OE,
  output logic            IRQ_PORT_PIN_O,
  output logic            IRQ_PORT_PIN_OE,
  output logic            SERIAL_OUT_PORT_PIN_O,
  output logic            SERIAL_OUT_PORT_PIN_OE
);
  logic [7:0] port_config_a;
  logic [7:0] port_config_b;
  logic [7:0] port_config_c;
  logic [7:0] test_register;
  logic [7:0] next_port_config_a;
  logic [7:0] next_port_config_b;
  logic [7:0] next_port_config_c;
  logic [7:0] next_test_register;
  logic [7:0] next_rdata;
  logic [1:0] data_pin_select;
  logic       data_pin_invert;
  logic [3:0] irq_pin_select;
  logic       irq_pin_invert;
  logic [2:0] serial_out_pin_select;
  logic       serial_out_pin_invert;
  logic       separate_serial_output;
  logic [2:0] digital_test_select;

  ppfm_pin_if data_pin ();
  ppfm_pin_if irq_pin ();
  ppfm_pin_if so_pin ();

  // register field views
  assign data_pin_select        = port_config_a[DATA_SEL_LSB +: 2];
  assign data_pin_invert        = port_config_a[DATA_INV_BIT];
  assign irq_pin_select         = port_config_a[IRQ_SEL_LSB +: 4];
  assign irq_pin_invert         = port_config_a[IRQ_INV_BIT];
  assign serial_out_pin_select  = port_config_b[SO_SEL_LSB +: 3];
  assign serial_out_pin_invert  = port_config_b[SO_INV_BIT];
  assign separate_serial_output = port_config_c[SEP_SO_BIT];
  assign digital_test_select    = test_register[TEST_SEL_LSB +: 3];

  // register writes and read-back
  always_comb begin
    next_port_config_a = port_config_a;
    next_port_config_b = port_config_b;
    next_port_config_c = port_config_c;
    next_test_register = test_register;
    if (REG_WR) begin
      case (REG_ADDR)
        PORT_CONFIG_A_ADDR: next_port_config_a = REG_WDATA;
        PORT_CONFIG_B_ADDR: next_port_config_b = REG_WDATA;
        PORT_CONFIG_C_ADDR: next_port_config_c = REG_WDATA;
        TEST_REGISTER_ADDR: next_test_register = REG_WDATA;
        default: ;
      endcase
    end
    case (REG_ADDR)
      PORT_CONFIG_A_ADDR: next_rdata = port_config_a;
      PORT_CONFIG_B_ADDR: next_rdata = port_config_b;
      PORT_CONFIG_C_ADDR: next_rdata = port_config_c;
      TEST_REGISTER_ADDR: next_rdata = test_register;
      default:            next_rdata = 8'h00;
    endcase
  end

  // register state
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      port_config_a <= PORT_CONFIG_A_RST;
      port_config_b <= PORT_CONFIG_B_RST;
      port_config_c <= PORT_CONFIG_C_RST;
      test_register <= TEST_REGISTER_RST;
      REG_RDATA     <= 8'h00;
    end else begin
      port_config_a <= next_port_config_a;
      port_config_b <= next_port_config_b;
      port_config_c <= next_port_config_c;
      test_register <= next_test_register;
      REG_RDATA     <= next_rdata;
    end
  end

  // data pin source
  always_comb begin
    data_pin.inv   = data_pin_invert;
    data_pin.drive = (data_pin_select != DATA_HIZ);
    case (data_pin_select)
      DATA_LOW:  data_pin.src = 1'b0;
      DATA_PSEUDO_RANDOM_GENERATOR: data_pin.src = PSEUDO_RANDOM_GENERATOR_OUT;
      default:   data_pin.src = 1'b0; // reserved reads low
    endcase
  end

  // irq pin source
  always_comb begin
    irq_pin.inv   = irq_pin_invert;
    irq_pin.drive = (irq_pin_select != IRQ_HIZ);
    case (irq_pin_select)
      4'h2:       irq_pin.src = IRQ_REQ;
      4'h3:       irq_pin.src = CLKGEN_OUT;
      4'h4:       irq_pin.src = IQ_CAL_RUNNING;
      4'h5:       irq_pin.src = LOCAL_OSC_READY;
      4'h6:       irq_pin.src = RX_READY;
      4'h7:       irq_pin.src = TX_READY;
      4'h8:       irq_pin.src = POWER_AMP_ON;
      4'h9:       irq_pin.src = POWER_AMP_ON_REQ;
      IRQ_TEST_1: irq_pin.src = TEST_GROUP_1[digital_test_select];
      IRQ_TEST_2: irq_pin.src = TEST_GROUP_2[digital_test_select];
      default:    irq_pin.src = 1'b0;              // zero, 10-13
    endcase
  end

  // serial-output pin source
  always_comb begin
    so_pin.inv   = serial_out_pin_invert;
    so_pin.drive = (serial_out_pin_select != SO_HIZ);
    case (serial_out_pin_select)
      3'h2:    so_pin.src = TX_MOD;
      3'h3:    so_pin.src = RX_READY | TX_READY;
      3'h4:    so_pin.src = REFERENCE_CLOCK_READY;
      3'h5:    so_pin.src = LOCAL_OSC_READY;
      3'h6:    so_pin.src = RX_READY;
      3'h7:    so_pin.src = TX_READY;
      default: so_pin.src = 1'b0;
    endcase
    if (separate_serial_output) begin
      so_pin.src   = SPI_SDO;
      so_pin.inv   = 1'b0;
      so_pin.drive = SPI_SDO_EN;
    end
  end

  // registered output stages, one per pin
  ppfm_pin_drv u_data (.core_clk(CORE_CLK), .reset_n(RESET_N),
                       .pin(data_pin));
  ppfm_pin_drv u_irq  (.core_clk(CORE_CLK), .reset_n(RESET_N),
                       .pin(irq_pin));
  ppfm_pin_drv u_so   (.core_clk(CORE_CLK), .reset_n(RESET_N),
                       .pin(so_pin));

  assign DATA_PORT_PIN_O        = data_pin.out;
  assign DATA_PORT_PIN_OE       = data_pin.oe;
  assign IRQ_PORT_PIN_O         = irq_pin.out;
  assign IRQ_PORT_PIN_OE        = irq_pin.oe;
  assign SERIAL_OUT_PORT_PIN_O  = so_pin.out;
  assign SERIAL_OUT_PORT_PIN_OE = so_pin.oe;

  // assertions: each pin shows its chosen source one edge later
  a_reg_readback: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    REG_WR && REG_ADDR == PORT_CONFIG_A_ADDR ##1 !REG_WR
      && REG_ADDR == PORT_CONFIG_A_ADDR |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("config a read-back mismatch");
  // a write to config a leaves the config b and c settings alone
  a_cfg_isolated: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    REG_WR && REG_ADDR == PORT_CONFIG_A_ADDR |=>
      $stable(port_config_b) && $stable(port_config_c))
    else $error("config a write disturbed other pins");
  a_data_hiz: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    data_pin_select == DATA_HIZ |=> !DATA_PORT_PIN_OE)
    else $error("data pin driven in hiz");
  a_data_low: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    data_pin_select == DATA_LOW |=> DATA_PORT_PIN_OE
      && DATA_PORT_PIN_O == $past(data_pin_invert))
    else $error("data pin low level wrong");
  a_data_pseudo_random_generator: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    data_pin_select == DATA_PSEUDO_RANDOM_GENERATOR |=>
      DATA_PORT_PIN_O == ($past(PSEUDO_RANDOM_GENERATOR_OUT) ^ $past(data_pin_invert)))
    else $error("data pin pseudo_random_generator level wrong");
  // the reserved data code is driven low, never left floating
  a_data_reserved: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    data_pin_select == 2'h3 |=> DATA_PORT_PIN_OE
      && DATA_PORT_PIN_O == $past(data_pin_invert))
    else $error("data pin reserved level wrong");
  a_irq_hiz: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    irq_pin_select == IRQ_HIZ |=> !IRQ_PORT_PIN_OE && !IRQ_PORT_PIN_O)
    else $error("irq pin driven in hiz");
  a_irq_zero: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    irq_pin_select == 4'h1 |=> IRQ_PORT_PIN_OE
      && IRQ_PORT_PIN_O == $past(irq_pin_invert))
    else $error("irq pin zero level wrong");
  a_irq_request: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    irq_pin_select == 4'h2 |=>
      IRQ_PORT_PIN_O == ($past(IRQ_REQ) ^ $past(irq_pin_invert)))
    else $error("irq pin request level wrong");
  a_irq_clock: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N) irq_pin_select == 4'h3 |=>
      IRQ_PORT_PIN_O == ($past(CLKGEN_OUT) ^ $past(irq_pin_invert)))
    else $error("irq pin clock level wrong");
  a_irq_cal_run: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N) irq_pin_select == 4'h4 |=>
      IRQ_PORT_PIN_O == ($past(IQ_CAL_RUNNING) ^ $past(irq_pin_invert)))
    else $error("irq pin calibration level wrong");
  a_irq_lo_ready: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N) irq_pin_select == 4'h5 |=>
      IRQ_PORT_PIN_O == ($past(LOCAL_OSC_READY) ^ $past(irq_pin_invert)))
    else $error("irq pin oscillator ready level wrong");
  a_irq_rx_ready: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N) irq_pin_select == 4'h6 |=>
      IRQ_PORT_PIN_O == ($past(RX_READY) ^ $past(irq_pin_invert)))
    else $error("irq pin receive ready level wrong");
  a_irq_tx_ready: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N) irq_pin_select == 4'h7 |=>
      IRQ_PORT_PIN_O == ($past(TX_READY) ^ $past(irq_pin_invert)))
    else $error("irq pin transmit ready level wrong");
  a_irq_power_amp_on: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N) irq_pin_select == 4'h8 |=>
      IRQ_PORT_PIN_O == ($past(POWER_AMP_ON) ^ $past(irq_pin_invert)))
    else $error("irq pin amplifier flag level wrong");
  a_irq_pa_req: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N) irq_pin_select == 4'h9 |=>
      IRQ_PORT_PIN_O == ($past(POWER_AMP_ON_REQ) ^ $past(irq_pin_invert)))
    else $error("irq pin amplifier request level wrong");
  a_irq_reserved: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    irq_pin_select inside {[4'hA:4'hD]} |=>
      IRQ_PORT_PIN_O == $past(irq_pin_invert))
    else $error("irq reserved not zero");
  a_irq_test_one: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    irq_pin_select == IRQ_TEST_1 |=> IRQ_PORT_PIN_O ==
      ($past(TEST_GROUP_1[digital_test_select]) ^ $past(irq_pin_invert)))
    else $error("irq test group one wrong");
  a_irq_test_two: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    irq_pin_select == IRQ_TEST_2 |=> IRQ_PORT_PIN_O ==
      ($past(TEST_GROUP_2[digital_test_select]) ^ $past(irq_pin_invert)))
    else $error("irq test group two wrong");
  a_so_hiz: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    !separate_serial_output && serial_out_pin_select == SO_HIZ |=>
      !SERIAL_OUT_PORT_PIN_OE)
    else $error("serial out driven in hiz");
  a_so_zero: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    !separate_serial_output && serial_out_pin_select == 3'h1 |=>
      SERIAL_OUT_PORT_PIN_O == $past(serial_out_pin_invert))
    else $error("serial out zero level wrong");
  a_so_modulation: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    !separate_serial_output && serial_out_pin_select == 3'h2 |=>
      SERIAL_OUT_PORT_PIN_O == ($past(TX_MOD) ^ $past(serial_out_pin_invert)))
    else $error("serial out modulation level wrong");
  a_so_either_rdy: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    !separate_serial_output && serial_out_pin_select == 3'h3 |=>
      SERIAL_OUT_PORT_PIN_O == (($past(RX_READY) | $past(TX_READY))
        ^ $past(serial_out_pin_invert)))
    else $error("serial out either ready level wrong");
  a_so_override: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    separate_serial_output |=> SERIAL_OUT_PORT_PIN_OE == $past(SPI_SDO_EN)
      && SERIAL_OUT_PORT_PIN_O == ($past(SPI_SDO) & $past(SPI_SDO_EN)))
    else $error("serial output override wrong");
  a_so_ready: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    !separate_serial_output && serial_out_pin_select == 3'h4 |=>
      SERIAL_OUT_PORT_PIN_O ==
        ($past(REFERENCE_CLOCK_READY) ^ $past(serial_out_pin_invert)))
    else $error("serial out ready wrong");
  a_irq_reset_inv: assert property (
    @(posedge CORE_CLK)
    $rose(RESET_N) |-> irq_pin_invert && irq_pin_select == 4'h2)
    else $error("irq reset defaults wrong");

  c_pseudo_random_generator_out: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
    data_pin_select == DATA_PSEUDO_RANDOM_GENERATOR ##1 DATA_PORT_PIN_OE);
  c_test_two: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
    irq_pin_select == IRQ_TEST_2 && digital_test_select == 3'h4);
  c_override: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
    separate_serial_output && SPI_SDO_EN);
  c_irq_clock: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
    irq_pin_select == 4'h3 ##1 IRQ_PORT_PIN_OE);
  c_reset_exit: cover property (@(posedge CORE_CLK)
    $rose(RESET_N) ##1 IRQ_PORT_PIN_OE);
endmodule : ppfm_port_mux

//--- verif/ppfm_host_model.sv
// host model: wire level that the host sees on each port pin
`timescale 1ns/100ps
module ppfm_host_model (
  // clock
  input  wire logic       clk,
  // pins from the device
  input  wire logic [2:0] pin_o,
  input  wire logic [2:0] pin_oe,
  // observed levels
  output logic      [2:0] seen
);
  logic [2:0] last = 3'h0;
  // a released pin shows a level that changes every cycle
  always_comb seen = (pin_oe & pin_o) | (~pin_oe & ~last);
  // remember the level seen
  always_ff @(posedge clk) last <= seen;
endmodule : ppfm_host_model

//--- verif/test_port_pin_function_mux.sv
// testbench: pin function rows, readback, test groups and resets
`timescale 1ns/100ps
module test_port_pin_function_mux;
  import ppfm_pkg::*;
  logic        CORE_CLK, RESET_N, REG_WR;
  logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, tg1, tg2;
  logic [12:0] src;
  logic [2:0]  pin_o, pin_oe, seen;
  int          mismatches, n_tests, cycles;
  // row: addr, data, pin, {oe,level} with pattern, {oe,level} with inverse
  localparam logic [23:0] ROWS [30] = '{
    24'h100000, 24'h10020A, 24'h10040E, 24'h10050B, 24'h10060A,
    24'h100010, 24'h10101A, 24'h10201B, 24'h10281E, 24'h10301E,
    24'h10401B, 24'h10501E, 24'h10601B, 24'h10701E, 24'h10801B,
    24'h10901E, 24'h10A01A, 24'h10B01A, 24'h10C01A, 24'h10D01A,
    24'h110020, 24'h11202A, 24'h11402B, 24'h11502E, 24'h11602F,
    24'h11802E, 24'h11A02E, 24'h11C02B, 24'h11E02E, 24'h128028};

  ppfm_port_mux i_dut (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_WR(REG_WR),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .PSEUDO_RANDOM_GENERATOR_OUT(src[0]), .IRQ_REQ(src[1]), .CLKGEN_OUT(src[2]),
    .IQ_CAL_RUNNING(src[3]), .LOCAL_OSC_READY(src[4]),
    .RX_READY(src[5]), .TX_READY(src[6]), .POWER_AMP_ON(src[7]),
    .POWER_AMP_ON_REQ(src[8]), .TX_MOD(src[9]),
    .REFERENCE_CLOCK_READY(src[10]), .SPI_SDO(src[11]),
    .SPI_SDO_EN(src[12]), .TEST_GROUP_1(tg1), .TEST_GROUP_2(tg2),
    .DATA_PORT_PIN_O(pin_o[0]), .DATA_PORT_PIN_OE(pin_oe[0]),
    .IRQ_PORT_PIN_O(pin_o[1]), .IRQ_PORT_PIN_OE(pin_oe[1]),
    .SERIAL_OUT_PORT_PIN_O(pin_o[2]), .SERIAL_OUT_PORT_PIN_OE(pin_oe[2]));

  ppfm_host_model i_host (
    .clk(CORE_CLK), .pin_o(pin_o), .pin_oe(pin_oe), .seen(seen));

  // clock generator, 25 ns period
  initial begin
    CORE_CLK = 1'b0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end

  // print the counts and the verdict, then stop
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  // compare one pin's enable and driven level, not the toggling level the host sees on a released pin
  task automatic chk(input int p, input logic [1:0] exp);
    logic [1:0] got;
    got = {pin_oe[p], pin_oe[p] ? seen[p] : pin_o[p]};
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: pin %0d got %b", $time, p, got);
    end
  endtask : chk

  // one write strobe, then one edge for the pin stage
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CORE_CLK);
    REG_WR = 1'b0;
    @(negedge CORE_CLK);
  endtask : wr

  // registered read, one cycle after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    REG_ADDR = a;
    @(negedge CORE_CLK);
    n_tests++;
    if (REG_RDATA !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: read %h got %h", $time, a, REG_RDATA);
    end
  endtask : rd

  // cut a hang short
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      $display("CHECK FAILED at %0t: timeout", $time);
      complete_run();
    end
  end

  // main sequence
  initial begin
    RESET_N = 1'b0;
    REG_WR = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    src = 13'h1555;
    tg1 = 8'hA5;
    tg2 = 8'h0A;
    repeat (20) @(negedge CORE_CLK);
    chk(1, 2'b00);
    RESET_N = 1'b1;
    @(negedge CORE_CLK);
    chk(1, 2'b11);
    chk(0, 2'b00);
    chk(2, 2'b00);
    rd(PORT_CONFIG_A_ADDR, 8'h28);
    rd(PORT_CONFIG_B_ADDR, 8'h06);
    rd(PORT_CONFIG_C_ADDR, 8'h00);
    rd(TEST_REGISTER_ADDR, 8'h00);
    // every select code except irq 14 and 15, with the sources and their inverse
    foreach (ROWS[i]) begin
      src = 13'h1555;
      wr(ROWS[i][23:16], ROWS[i][15:8]);
      chk(ROWS[i][5:4], ROWS[i][3:2]);
      src = ~13'h1555;
      @(negedge CORE_CLK);
      chk(ROWS[i][5:4], ROWS[i][1:0]);
    end
    // readback, inverted constant low, unmapped write ignored
    wr(PORT_CONFIG_C_ADDR, 8'h00);
    wr(PORT_CONFIG_A_ADDR, 8'hC3);
    chk(0, 2'b11);
    chk(1, 2'b10);
    wr(8'h13, 8'hFF);
    rd(PORT_CONFIG_A_ADDR, 8'hC3);
    rd(8'h13, 8'h00);
    // both test groups, every test select code
    for (int g = 0; g < 2; g++) begin
      for (int c = 0; c < 8; c++) begin
        tg1 = 8'hA5;
        tg2 = 8'h0A;
        wr(TEST_REGISTER_ADDR, 8'(c << 4));
        wr(PORT_CONFIG_A_ADDR, g ? 8'hF0 : 8'hE0);
        chk(1, {1'b1, g ? tg2[c] : tg1[c]});
        tg1 = 8'h5A;
        tg2 = 8'h15;
        @(negedge CORE_CLK);
        chk(1, {1'b1, g ? tg2[c] : tg1[c]});
      end
    end
    rd(TEST_REGISTER_ADDR, 8'h70);
    // inverted transmit ready, then override with the enable both ways
    wr(PORT_CONFIG_B_ADDR, 8'hF0);
    chk(2, 2'b11);
    wr(PORT_CONFIG_C_ADDR, 8'h80);
    chk(2, 2'b00);
    src = 13'h1800;
    @(negedge CORE_CLK);
    chk(2, 2'b11);
    rd(PORT_CONFIG_B_ADDR, 8'hF0);
    rd(PORT_CONFIG_C_ADDR, 8'h80);
    // reset in mid-run restores the defaults and releases the pins
    RESET_N = 1'b0;
    @(negedge CORE_CLK);
    chk(1, 2'b00);
    chk(2, 2'b00);
    RESET_N = 1'b1;
    rd(PORT_CONFIG_A_ADDR, 8'h28);
    chk(1, 2'b11);
    chk(2, 2'b00);
    rd(PORT_CONFIG_C_ADDR, 8'h00);
    complete_run();
  end
endmodule : test_port_pin_function_mux
